// *** core/picp_pkg.sv ***
package picp_pkg;

  // Clock period of mclk_i in nanoseconds.
  localparam int CLK_NS = 20;

  // Converts a least time in nanoseconds to whole clock cycles, never below one.
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Pin timing in nanoseconds.
  localparam int T_SETUP_NS  = 50;
  localparam int T_RD_NS     = 420;
  localparam int T_WR_NS     = 400;
  localparam int T_HOLD_NS   = 40;
  localparam int T_RREC_NS   = 160;
  localparam int T_WREC_NS   = 190;
  localparam int T_REQLOW_NS = 100;

  // Pin timing in clock cycles.
  localparam logic [4:0] C_SETUP  = 5'(ceil_cyc(T_SETUP_NS));
  localparam logic [4:0] C_RD     = 5'(ceil_cyc(T_RD_NS));
  localparam logic [4:0] C_WR     = 5'(ceil_cyc(T_WR_NS));
  localparam logic [4:0] C_HOLD   = 5'(ceil_cyc(T_HOLD_NS));
  localparam logic [4:0] C_RREC   = 5'(ceil_cyc(T_RREC_NS));
  localparam logic [4:0] C_WREC   = 5'(ceil_cyc(T_WREC_NS));
  localparam logic [4:0] C_REQLOW = 5'(ceil_cyc(T_REQLOW_NS));

  // Register addresses of the local port.
  localparam logic [2:0] ADDR_CMD    = 3'h0;
  localparam logic [2:0] ADDR_ACK    = 3'h1;
  localparam logic [2:0] ADDR_REQ    = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_VEC    = 3'h4;

  // Command, acknowledge and request register fields.
  localparam int CMD_DATA_LSB  = 0;
  localparam int CMD_A0_BIT    = 8;
  localparam int CMD_TGT_LSB   = 9;
  localparam int CMD_RD_BIT    = 13;
  localparam int CMD_TWICE_BIT = 14;
  localparam int CMD_SLV_LSB   = 15;
  localparam int ACK_THREE_BIT = 0;
  localparam int REQ_PULSE_LSB = 8;

  // Number of controllers with their own chip select: one master, eight slaves.
  localparam int NUM_CS = 9;

  // Pulse indices of the acknowledge sequence.
  localparam logic [1:0] PULSE_LAST2 = 2'h1;
  localparam logic [1:0] PULSE_LAST3 = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD   = 3'h2,
    ST_RECOV  = 3'h6
  } picp_state_t;

  typedef enum logic [1:0] {
    OP_WR  = 2'h0,
    OP_RD  = 2'h1,
    OP_ACK = 2'h2
  } picp_op_t;

endpackage

// *** core/picp_host.sv ***
`timescale 1ns/10ps
//
// Function
// - Each controller gets its own initialisation sequence, selected by its chip select.
// - A slave-routed request needs end-of-service sent to master and then slave.
// - Each controller gets its own active-low chip select.
// - A source raises its request and holds it, or pulses it low.
// - A request low pulse lasts at least 100 ns.
// - Acknowledge runs as three pulses or two, with vector bytes to match.
module picp_host (
  input  wire logic                        mclk_i,
  input  wire logic                        srst_i,
  input  wire logic [2:0]                  addr_i,
  input  wire logic [31:0]                 wdata_i,
  input  wire logic                        we_i,
  input  wire logic                        re_i,
  output logic      [31:0]                 rdata_o,
  output logic      [picp_pkg::NUM_CS-1:0] cs_n_o,
  output logic                             port_select_bit_o,
  output logic                             rd_n_o,
  output logic                             wr_n_o,
  output logic                             acknowledge_strobe_n_o,
  input  wire logic [7:0]                  data_i,
  output logic      [7:0]                  data_o,
  output logic                             data_oe_o,
  input  wire logic                        int_i,
  output logic      [7:0]                  request_inputs_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  picp_pkg::picp_state_t state_q, state_d;
  picp_pkg::picp_op_t    op_q, op_d;
  logic [4:0]            cnt_q, cnt_d;
  logic [1:0]            pulse_q, pulse_d;
  logic                  three_q, three_d;
  logic                  twice_q, twice_d;
  logic                  pass_q, pass_d;
  logic [3:0]            tgt_q, tgt_d;
  logic [3:0]            slv_q, slv_d;
  logic                  a0_q, a0_d;
  logic [7:0]            wdat_q, wdat_d;
  logic [7:0]            rdat_q, rdat_d;
  logic [7:0]            vec_q [0:2];
  logic [7:0]            vec_d [0:2];
  logic [7:0]            req_lvl_q, req_lvl_d;
  logic [7:0]            req_pm_q, req_pm_d;
  logic [4:0]            req_cnt_q, req_cnt_d;
  logic [31:0]           rdata_q, rdata_d;
  logic                  busy;

  // Pin synchronisers.
  logic [7:0]            data_m_q, data_s_q;
  logic                  int_m_q, int_s_q;

  // Registered pin drives.
  logic [picp_pkg::NUM_CS-1:0] cs_n_q, cs_n_d;
  logic                  a0p_q, a0p_d;
  logic                  rd_n_q, rd_n_d;
  logic                  wr_n_q, wr_n_d;
  logic                  ak_n_q, ak_n_d;
  logic [7:0]            dout_q, dout_d;
  logic                  doe_q, doe_d;
  logic [7:0]            reqo_q, reqo_d;

  assign busy = (state_q != picp_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Pin cycle sequencer and register port.
  always_comb begin
    state_d   = state_q;
    op_d      = op_q;
    cnt_d     = cnt_q;
    pulse_d   = pulse_q;
    three_d   = three_q;
    twice_d   = twice_q;
    pass_d    = pass_q;
    tgt_d     = tgt_q;
    slv_d     = slv_q;
    a0_d      = a0_q;
    wdat_d    = wdat_q;
    rdat_d    = rdat_q;
    vec_d     = vec_q;
    req_lvl_d = req_lvl_q;
    req_pm_d  = req_pm_q;
    req_cnt_d = req_cnt_q;
    rdata_d   = 32'h0000_0000;
    unique case (state_q)
      picp_pkg::ST_IDLE: begin
        if (we_i && addr_i == picp_pkg::ADDR_CMD) begin
          // Mode words, mask loads and status reads go to the chip select in tgt, then also to slv when the twice bit is set.
          op_d    = wdata_i[picp_pkg::CMD_RD_BIT] ? picp_pkg::OP_RD : picp_pkg::OP_WR;
          a0_d    = wdata_i[picp_pkg::CMD_A0_BIT];
          wdat_d  = wdata_i[picp_pkg::CMD_DATA_LSB +: 8];
          tgt_d   = wdata_i[picp_pkg::CMD_TGT_LSB +: 4];
          slv_d   = wdata_i[picp_pkg::CMD_SLV_LSB +: 4];
          twice_d = wdata_i[picp_pkg::CMD_TWICE_BIT];
          pass_d  = 1'b0;
          cnt_d   = picp_pkg::C_SETUP - 5'h01;
          state_d = picp_pkg::ST_SETUP;
        end else if (we_i && addr_i == picp_pkg::ADDR_ACK) begin
          op_d    = picp_pkg::OP_ACK;
          three_d = wdata_i[picp_pkg::ACK_THREE_BIT];
          pulse_d = 2'h0;
          twice_d = 1'b0;
          pass_d  = 1'b0;
          cnt_d   = picp_pkg::C_SETUP - 5'h01;
          state_d = picp_pkg::ST_SETUP;
        end
      end
      picp_pkg::ST_SETUP: begin
        if (cnt_q == 5'h00) begin
          cnt_d   = ((op_q == picp_pkg::OP_WR) ? picp_pkg::C_WR : picp_pkg::C_RD) - 5'h01;
          state_d = picp_pkg::ST_STROBE;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      picp_pkg::ST_STROBE: begin
        if (cnt_q == 5'h00) begin
          // Sample the bus in the last low cycle, long after data valid.
          if (op_q == picp_pkg::OP_RD) begin
            rdat_d = data_s_q;
          end else if (op_q == picp_pkg::OP_ACK) begin
            vec_d[pulse_q] = data_s_q;
          end
          cnt_d   = picp_pkg::C_HOLD - 5'h01;
          state_d = picp_pkg::ST_HOLD;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      picp_pkg::ST_HOLD: begin
        if (cnt_q == 5'h00) begin
          cnt_d   = ((op_q == picp_pkg::OP_WR) ? picp_pkg::C_WREC : picp_pkg::C_RREC) - 5'h01;
          state_d = picp_pkg::ST_RECOV;
        end else begin
          cnt_d = cnt_q - 5'h01;
        end
      end
      picp_pkg::ST_RECOV: begin
        if (cnt_q != 5'h00) begin
          cnt_d = cnt_q - 5'h01;
        end else if (op_q == picp_pkg::OP_ACK &&
                     pulse_q != (three_q ? picp_pkg::PULSE_LAST3 : picp_pkg::PULSE_LAST2)) begin
          pulse_d = pulse_q + 2'h1;
          cnt_d   = picp_pkg::C_SETUP - 5'h01;
          state_d = picp_pkg::ST_SETUP;
        end else if (twice_q && !pass_q) begin
          // Second end-of-service copy goes to the slave concerned.
          pass_d  = 1'b1;
          tgt_d   = slv_q;
          cnt_d   = picp_pkg::C_SETUP - 5'h01;
          state_d = picp_pkg::ST_SETUP;
        end else begin
          state_d = picp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = picp_pkg::ST_IDLE;
      end
    endcase
    // Request lines: a held level plus an optional low pulse of least width.
    if (req_cnt_q != 5'h00) begin
      req_cnt_d = req_cnt_q - 5'h01;
      if (req_cnt_q == 5'h01) begin
        req_pm_d = 8'h00;
      end
    end
    if (we_i && addr_i == picp_pkg::ADDR_REQ) begin
      req_lvl_d = wdata_i[7:0];
      if (req_cnt_q == 5'h00 && wdata_i[picp_pkg::REQ_PULSE_LSB +: 8] != 8'h00) begin
        req_pm_d  = wdata_i[picp_pkg::REQ_PULSE_LSB +: 8];
        req_cnt_d = picp_pkg::C_REQLOW;
      end
    end
    // Read answers.
    if (re_i) begin
      unique case (addr_i)
        picp_pkg::ADDR_STATUS: rdata_d = {22'h00_0000, rdat_q, int_s_q, busy};
        picp_pkg::ADDR_VEC:    rdata_d = {8'h00, vec_q[2], vec_q[1], vec_q[0]};
        picp_pkg::ADDR_REQ:    rdata_d = {16'h0000, req_pm_q, req_lvl_q};
        default:               rdata_d = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drives, registered so the pins never glitch.
  always_comb begin
    cs_n_d = {picp_pkg::NUM_CS{1'b1}};
    a0p_d  = a0_q;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    ak_n_d = 1'b1;
    dout_d = wdat_q;
    doe_d  = 1'b0;
    reqo_d = req_lvl_q & ~req_pm_q;
    // Acknowledge runs with every chip select high.
    if (busy && op_q != picp_pkg::OP_ACK && 32'(tgt_q) < picp_pkg::NUM_CS) begin
      cs_n_d[tgt_q] = 1'b0;
    end
    if (state_q == picp_pkg::ST_STROBE) begin
      rd_n_d = (op_q != picp_pkg::OP_RD);
      wr_n_d = (op_q != picp_pkg::OP_WR);
      ak_n_d = (op_q != picp_pkg::OP_ACK);
    end
    if (busy && op_q == picp_pkg::OP_WR) begin
      doe_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q   <= picp_pkg::ST_IDLE;
      op_q      <= picp_pkg::OP_WR;
      cnt_q     <= 5'h00;
      pulse_q   <= 2'h0;
      three_q   <= 1'b0;
      twice_q   <= 1'b0;
      pass_q    <= 1'b0;
      tgt_q     <= 4'h0;
      slv_q     <= 4'h0;
      a0_q      <= 1'b0;
      wdat_q    <= 8'h00;
      rdat_q    <= 8'h00;
      vec_q     <= '{8'h00, 8'h00, 8'h00};
      req_lvl_q <= 8'h00;
      req_pm_q  <= 8'h00;
      req_cnt_q <= 5'h00;
      rdata_q   <= 32'h0000_0000;
      data_m_q  <= 8'h00;
      data_s_q  <= 8'h00;
      int_m_q   <= 1'b0;
      int_s_q   <= 1'b0;
      cs_n_q    <= {picp_pkg::NUM_CS{1'b1}};
      a0p_q     <= 1'b0;
      rd_n_q    <= 1'b1;
      wr_n_q    <= 1'b1;
      ak_n_q    <= 1'b1;
      dout_q    <= 8'h00;
      doe_q     <= 1'b0;
      reqo_q    <= 8'h00;
    end else begin
      state_q   <= state_d;
      op_q      <= op_d;
      cnt_q     <= cnt_d;
      pulse_q   <= pulse_d;
      three_q   <= three_d;
      twice_q   <= twice_d;
      pass_q    <= pass_d;
      tgt_q     <= tgt_d;
      slv_q     <= slv_d;
      a0_q      <= a0_d;
      wdat_q    <= wdat_d;
      rdat_q    <= rdat_d;
      vec_q     <= vec_d;
      req_lvl_q <= req_lvl_d;
      req_pm_q  <= req_pm_d;
      req_cnt_q <= req_cnt_d;
      rdata_q   <= rdata_d;
      data_m_q  <= data_i;
      data_s_q  <= data_m_q;
      int_m_q   <= int_i;
      int_s_q   <= int_m_q;
      cs_n_q    <= cs_n_d;
      a0p_q     <= a0p_d;
      rd_n_q    <= rd_n_d;
      wr_n_q    <= wr_n_d;
      ak_n_q    <= ak_n_d;
      dout_q    <= dout_d;
      doe_q     <= doe_d;
      reqo_q    <= reqo_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign rdata_o                = rdata_q;
  assign cs_n_o                 = cs_n_q;
  assign port_select_bit_o      = a0p_q;
  assign rd_n_o                 = rd_n_q;
  assign wr_n_o                 = wr_n_q;
  assign acknowledge_strobe_n_o = ak_n_q;
  assign data_o                 = dout_q;
  assign data_oe_o              = doe_q;
  assign request_inputs_o       = reqo_q;

endmodule

// *** dv/picp_dev_model.sv ***
`timescale 1ns/10ps
// Behavioural interrupt controller, seen only through its pins.
module picp_dev_model (
  input  wire logic       clk_i,
  input  wire logic       cs_n_i,
  input  wire logic       a0_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       ack_n_i,
  input  wire logic [7:0] bus_i,
  input  wire logic [7:0] req_i,
  output logic      [7:0] data_o,
  output logic            int_o
);
  logic [7:0] mask_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic       smm_q  = 1'b0;
  logic       wr_q   = 1'b1;
  logic       ack_q  = 1'b1;
  logic [1:0] cnt_q  = 2'h0;
  logic [4:0] idle_q = 5'h00;
  logic       wr_end;
  logic       drv;
  // A write lands on the trailing edge of the write strobe while selected.
  assign wr_end = wr_n_i && !wr_q && !cs_n_i;
  // State follows the pins; a long quiet acknowledge line ends a sequence.
  always @(posedge clk_i) begin
    wr_q <= wr_n_i;
    ack_q <= ack_n_i;
    idle_q <= ack_n_i ? idle_q + {4'h0, idle_q != 5'h1F} : 5'h00;
    if (wr_end && a0_i) mask_q <= bus_i;
    if (wr_end && !a0_i && bus_i[6] && bus_i[3] && !bus_i[4] && !bus_i[7]) smm_q <= bus_i[5];
    if (ack_n_i && !ack_q) cnt_q <= cnt_q + 2'h1;
    else if (idle_q == 5'h14) cnt_q <= 2'h0;
    if (drv) last_q <= data_o;
  end
  // Acknowledge drives the bus without chip select; a read needs it.
  assign drv = !ack_n_i || (!rd_n_i && !cs_n_i);
  // A released bus shows the inverse of its last value, never a stale copy.
  assign data_o = !drv ? ~last_q : !ack_n_i ? {6'h28, cnt_q} : a0_i ? mask_q : {7'h00, smm_q};
  assign int_o = |(req_i & ~mask_q);
endmodule

// *** dv/picp_host_props.sv ***
`timescale 1ns/10ps
// Pin timing checks on the device side of the host controller.
module picp_host_props (
  input wire logic       mclk_i,
  input wire logic       srst_i,
  input wire logic [8:0] cs_n_o,
  input wire logic       port_select_bit_o,
  input wire logic       rd_n_o,
  input wire logic       wr_n_o,
  input wire logic       acknowledge_strobe_n_o,
  input wire logic       data_oe_o,
  input wire logic [7:0] request_inputs_o
);
  logic [5:0] wlow_q;
  logic [5:0] wlow_d;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  // Counts the low cycles of one write strobe.
  always_comb wlow_d = wr_n_o ? 6'h00 : wlow_q + 6'h01;
  always_ff @(posedge mclk_i) wlow_q <= srst_i ? 6'h00 : wlow_d;
  ////////////////////////////////////////////////////////////
  // Chip select, strobes, bus direction and request pulses.
  a_ack_no_cs: assert property (!acknowledge_strobe_n_o |-> &cs_n_o)
    else $error("chip select low during acknowledge");
  a_cs_onehot: assert property ($onehot0(~cs_n_o))
    else $error("more than one chip select low");
  a_strobe_cs: assert property ((!rd_n_o || !wr_n_o) |-> !(&cs_n_o))
    else $error("strobe without chip select");
  a_cs_setup: assert property (($fell(rd_n_o) || $fell(wr_n_o)) |-> $past(cs_n_o, 3) == cs_n_o)
    else $error("chip select setup short");
  a_sel_stable: assert property ((!rd_n_o || !wr_n_o) |=> $stable(cs_n_o) && $stable(port_select_bit_o))
    else $error("select moved during strobe");
  a_wr_width: assert property ($rose(wr_n_o) |-> wlow_q == 6'h14)
    else $error("write strobe width wrong");
  a_bus_turn: assert property ((!rd_n_o || !acknowledge_strobe_n_o) |-> !data_oe_o)
    else $error("host drives bus while device answers");
  a_data_hold: assert property ($rose(wr_n_o) |-> data_oe_o [*2])
    else $error("write data not held");
  a_req_low: assert property ($fell(request_inputs_o[0]) |-> !request_inputs_o[0] [*5])
    else $error("request low pulse too short");
  c_write: cover property ($fell(wr_n_o));
  c_ack: cover property ($fell(acknowledge_strobe_n_o));
  c_pulse: cover property ($fell(request_inputs_o[0]));
endmodule
bind picp_host picp_host_props props_u (.mclk_i, .srst_i, .cs_n_o, .port_select_bit_o, .rd_n_o, .wr_n_o,
  .acknowledge_strobe_n_o, .data_oe_o, .request_inputs_o);

// *** dv/picp_host_bench.sv ***
`timescale 1ns/10ps
// Self-checking bench: host controller driving a behavioural device.
module picp_host_bench;
  logic        mclk_i  = 1'b0;
  logic        srst_i  = 1'b1;
  logic [2:0]  addr_i  = 3'h0;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        we_i    = 1'b0;
  logic        re_i    = 1'b0;
  logic [31:0] rdata_o;
  logic [8:0]  cs_n_o;
  logic        a0;
  logic        rd_n;
  logic        wr_n;
  logic        ack_n;
  logic        data_oe;
  logic        dev_int;
  logic [7:0]  host_data;
  logic [7:0]  dev_data;
  logic [7:0]  bus;
  logic [7:0]  request;
  logic [31:0] v;
  int          errors = 0;
  int          checks = 0;
  // Clock at 50 MHz.
  always #10 mclk_i = ~mclk_i;
  // The data bus carries whichever side drives it.
  assign bus = data_oe ? host_data : dev_data;
  picp_host dut_u (.mclk_i, .srst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .cs_n_o,
    .port_select_bit_o(a0), .rd_n_o(rd_n), .wr_n_o(wr_n), .acknowledge_strobe_n_o(ack_n), .data_i(bus),
    .data_o(host_data), .data_oe_o(data_oe), .int_i(dev_int), .request_inputs_o(request));
  picp_dev_model dev_u (.clk_i(mclk_i), .cs_n_i(cs_n_o[0]), .a0_i(a0), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .ack_n_i(ack_n), .bus_i(bus), .req_i(request), .data_o(dev_data), .int_o(dev_int));
  ////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // One write cycle on the local port.
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge mclk_i);
    we_i <= 1'b0;
  endtask
  // One read cycle; the data stand only in the following cycle.
  task automatic rd(input logic [2:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge mclk_i);
    re_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  // Starts a pin cycle and polls busy; the last status read stays in v.
  task automatic go(input logic [31:0] d, input logic [2:0] a = picp_pkg::ADDR_CMD);
    int n;
    wr(a, d);
    n = 0;
    v = 32'h0000_0001;
    while (v[0] && n < 300) begin
      rd(picp_pkg::ADDR_STATUS);
      n++;
    end
    if (v[0] !== 1'b0) begin
      errors++;
      $display("unexpected busy expected 0 seen %b", v[0]);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Cuts a hung run short long after the tests should have ended.
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(picp_pkg::ADDR_STATUS);
    chk("status", 32'h0000_0000, v);
    rd(3'h7);
    chk("unmapped", 32'h0000_0000, v);
    go(32'h0000_015A);
    go(32'h0000_0333);
    go(32'h0000_2100);
    chk("mask", 32'h0000_0168, v & 32'h0000_03FF);
    for (int i = 0; i < 2; i++) begin
      go(i ? 32'h0000_0048 : 32'h0000_0068);
      go(32'h0000_2000);
      chk("special mask", i ? 32'h0000_0000 : 32'h0000_0004, v & 32'h0000_03FC);
    end
    wr(picp_pkg::ADDR_REQ, 32'h0000_0002);
    go(32'h0000_2100);
    chk("masked request", 32'h0000_0168, v & 32'h0000_03FF);
    wr(picp_pkg::ADDR_REQ, 32'h0000_0001);
    go(32'h0000_2100);
    chk("open request", 32'h0000_016A, v & 32'h0000_03FF);
    wr(picp_pkg::ADDR_REQ, 32'h0000_0101);
    rd(picp_pkg::ADDR_REQ);
    chk("request levels", 32'h0000_0101, v & 32'h0000_FFFF);
    for (int i = 0; i < 2; i++) begin
      go(i ? 32'h0000_0000 : 32'h0000_0001, picp_pkg::ADDR_ACK);
      rd(picp_pkg::ADDR_VEC);
      chk("vector", i ? 32'h0000_A1A0 : 32'h00A2_A1A0, v & (i ? 32'h0000_FFFF : 32'h00FF_FFFF));
      go(32'h0000_2100);
    end
    // First copy goes to a slave select, so only the second copy can reach the model.
    go(32'h0000_4355);
    go(32'h0000_2100);
    chk("mask twice", 32'h0000_0154, v & 32'h0000_03FF);
    @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(picp_pkg::ADDR_REQ);
    chk("request after reset", 32'h0000_0000, v & 32'h0000_00FF);
    rd(picp_pkg::ADDR_STATUS);
    chk("status after reset", 32'h0000_0000, v & 32'h0000_0003);
    complete_run();
  end
endmodule
